// file: rtl/sfd_decoder.sv
// serial flash instruction decoder: framing, phases, status and id returns
// Notes on behaviour
// - chip select fall starts a new frame
// - first byte after select is the opcode
// - sample on rising clock, msb first
// - chip select rise ends any instruction
// - write-type needs whole bytes else aborted
// - while busy only status reads accepted
// - 05h returns status low byte
// - 35h returns status high byte
// - status and id bytes repeat until deselect
// - 01h loads low then optional high byte
// - 31h loads the status high byte
// - past 256 bytes wrap within page
// - 90h returns maker then part code, part code first when address bit 0 is set
// - ABh three dummies, part code, wakes device
// - 3Bh single address, dual data out
// - dual out: line1 odd, line0 even bits
// - BBh address and mode on two lines
// - 6Bh single address, quad data out
// - 94h quad address, dummies, quad ids
// - quad lines only when quad bit set
// - 75h sets suspend, 7Ah clears it
// - protected target ignores program or erase
`timescale 1ns/10ps
`default_nettype none
`include "sfd_regs.svh"
module sfd_decoder #(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3C  // arbitrary value
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // serial link pins
  input  wire logic               sck,
  input  wire logic               cs_n,
  input  wire logic [3:0]         io_in,
  output var  logic [3:0]         io_out,
  output var  logic [3:0]         io_oe,
  // array side
  input  wire logic               busy,
  input  wire logic               prot_hit,
  input  wire logic [7:0]         arr_rd_data,
  output var  logic [23:0]        arr_addr,
  output var  logic [23:0]        tgt_addr,
  output var  logic [1:0]         erase_kind,
  output var  logic               pgm_start,
  output var  logic               erase_start,
  output var  logic [8:0]         pgm_len,
  input  wire logic [7:0]         buf_rd_addr,
  output var  logic [7:0]         buf_rd_data,
  // status view
  output var  logic [7:0]         status_low_byte,
  output var  logic [7:0]         status_high_byte,
  output var  logic               quad_lines_enable_bit,
  output var  logic               suspend_flag,
  output var  logic               four_line_command_mode,
  output var  logic               deep_down
);
  import sfd_pkg::*;

  // ========================================================================
  // helpers
  function automatic logic [3:0] lane_bits(input sfd_lane_e l);
    unique case (l)
      LN_1:    return 4'h1;
      LN_2:    return 4'h2;
      default: return 4'h4;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] io,
                                          input sfd_lane_e l);
    unique case (l)
      LN_1:    return {s[6:0], io[0]};
      LN_2:    return {s[5:0], io[1:0]};
      default: return {s[3:0], io};
    endcase
  endfunction

  // ========================================================================
  // link synchronisers and edge finding
  logic [1:0] sck_s_q;
  logic [1:0] cs_s_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic       sck_p_q;
  logic       cs_p_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       sel;

  // two flops on every pin, then one more for edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_s_q <= 2'h0;
      cs_s_q  <= 2'h3;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      cs_s_q  <= {cs_s_q[0], cs_n};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      sck_p_q <= sck_s_q[1];
      cs_p_q  <= cs_s_q[1];
    end
  end

  assign sel      = ~cs_s_q[1];
  assign sck_rise = sck_s_q[1] & ~sck_p_q & sel;
  assign sck_fall = ~sck_s_q[1] & sck_p_q & sel;
  assign cs_fall  = ~cs_s_q[1] & cs_p_q;
  assign cs_rise  = cs_s_q[1] & ~cs_p_q;

  // ========================================================================
  // frame state
  sfd_state_e st_q;
  sfd_state_e post_q;
  sfd_lane_e  aln_q;
  sfd_lane_e  dln_q;
  sfd_lane_e  in_ln;
  sfd_src_e   src_q;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic [2:0]  bc_q;
  logic [3:0]  bc_sum;
  logic        byte_done;
  logic [3:0]  nb_q;
  logic [7:0]  op_q;
  logic [2:0]  cnt_q;
  logic [1:0]  dum_q;
  logic        mode_q;
  logic [31:0] addr_q;
  logic [23:0] start_addr;
  logic [7:0]  wb0_q;
  logic [7:0]  wb1_q;
  logic [8:0]  wcnt_q;
  logic [7:0]  wptr_q;
  logic        buf_we;
  logic [7:0]  buf_wa;

  // lines of the current input phase
  always_comb begin
    unique case (st_q)
      SFD_OPC:          in_ln = four_line_command_mode ? LN_4 : LN_1;
      SFD_ADR, SFD_DUM: in_ln = aln_q;
      default:          in_ln = dln_q;
    endcase
  end

  assign sh_d       = shift_in(sh_q, io_s2_q, in_ln);
  assign bc_sum     = {1'b0, bc_q} + lane_bits(in_ln);
  assign byte_done  = sck_rise && (bc_sum == 4'h8);
  assign start_addr = mode_q ? addr_q[31:8] : addr_q[23:0];

  // ========================================================================
  // opcode decode
  sfd_state_e dec_st;
  sfd_state_e dec_post;
  sfd_lane_e  dec_aln;
  sfd_lane_e  dec_dln;
  sfd_src_e   dec_src;
  logic [2:0] dec_cnt;
  logic [1:0] dec_dum;
  logic       dec_mode;
  logic       quad_op;

  always_comb begin
    dec_st   = SFD_IGN;
    dec_post = SFD_RD;
    dec_aln  = four_line_command_mode ? LN_4 : LN_1;
    dec_dln  = dec_aln;
    dec_src  = SRC_ARR;
    dec_cnt  = 3'h3;
    dec_dum  = 2'h0;
    dec_mode = 1'b0;
    unique case (sh_d)
      `SFD_OP_RD_SLO: begin
        dec_st  = SFD_RD;
        dec_src = SRC_SLO;
      end
      `SFD_OP_RD_SHI: begin
        dec_st  = SFD_RD;
        dec_src = SRC_SHI;
      end
      `SFD_OP_READ: dec_st = SFD_ADR;
      `SFD_OP_FREAD: begin
        dec_st  = SFD_ADR;
        dec_dum = 2'h1;
      end
      `SFD_OP_DOUT, `SFD_OP_QOUT: begin
        dec_st  = SFD_ADR;
        dec_dum = 2'h1;
        dec_dln = (sh_d == `SFD_OP_DOUT) ? LN_2 : LN_4;
      end
      `SFD_OP_DIO: begin
        dec_st   = SFD_ADR;
        dec_cnt  = 3'h4;
        dec_mode = 1'b1;
        dec_aln  = LN_2;
        dec_dln  = LN_2;
      end
      `SFD_OP_QIO, `SFD_OP_QIDS: begin
        dec_st   = SFD_ADR;
        dec_cnt  = 3'h4;
        dec_mode = 1'b1;
        dec_dum  = 2'h2;
        dec_aln  = LN_4;
        dec_dln  = LN_4;
        dec_src  = (sh_d == `SFD_OP_QIDS) ? SRC_ID : SRC_ARR;
      end
      `SFD_OP_IDS: begin
        dec_st  = SFD_ADR;
        dec_src = SRC_ID;
      end
      `SFD_OP_WAKE: begin
        dec_st  = SFD_ADR;
        dec_src = SRC_PART;
      end
      `SFD_OP_PROG, `SFD_OP_QPROG, `SFD_OP_ER4K, `SFD_OP_ER32K, `SFD_OP_ER64K: begin
        dec_st   = SFD_ADR;
        dec_post = SFD_WR;
        if (sh_d == `SFD_OP_QPROG) dec_dln = LN_4;
      end
      `SFD_OP_WREN, `SFD_OP_WREN_V, `SFD_OP_WRDI, `SFD_OP_WR_STAT, `SFD_OP_WR_SHI,
      `SFD_OP_ERCHIP, `SFD_OP_ERCHIP2, `SFD_OP_HALT, `SFD_OP_RESUME, `SFD_OP_SLEEP,
      `SFD_OP_FLM_ON, `SFD_OP_FLM_OFF: dec_st = SFD_WR;
      default: dec_st = SFD_IGN;
    endcase
    quad_op = (sh_d == `SFD_OP_QOUT) || (sh_d == `SFD_OP_QIO) || (sh_d == `SFD_OP_QIDS)
           || (sh_d == `SFD_OP_QPROG) || (sh_d == `SFD_OP_FLM_ON);
    if (!quad_lines_enable_bit && quad_op) dec_st = SFD_IGN;
    if (busy && sh_d != `SFD_OP_RD_SLO && sh_d != `SFD_OP_RD_SHI) dec_st = SFD_IGN;
    if (deep_down && sh_d != `SFD_OP_WAKE) dec_st = SFD_IGN;
  end

  // ========================================================================
  // phase sequencing on sampled rising edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= SFD_OPC;
      post_q <= SFD_RD;
      aln_q  <= LN_1;
      dln_q  <= LN_1;
      src_q  <= SRC_ARR;
      sh_q   <= 8'h00;
      bc_q   <= 3'h0;
      nb_q   <= 4'h0;
      op_q   <= 8'h00;
      cnt_q  <= 3'h0;
      dum_q  <= 2'h0;
      mode_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (cs_fall) begin
      st_q <= SFD_OPC;
      bc_q <= 3'h0;
      nb_q <= 4'h0;
    end else if (sck_rise) begin
      sh_q <= sh_d;
      bc_q <= bc_sum[2:0];
      if (byte_done && nb_q != 4'hF) nb_q <= nb_q + 4'h1;
      if (byte_done) begin
        unique case (st_q)
          SFD_OPC: begin
            op_q   <= sh_d;
            st_q   <= dec_st;
            post_q <= dec_post;
            aln_q  <= dec_aln;
            dln_q  <= dec_dln;
            src_q  <= dec_src;
            cnt_q  <= dec_cnt;
            dum_q  <= dec_dum;
            mode_q <= dec_mode;
          end
          SFD_ADR: begin
            addr_q <= {addr_q[23:0], sh_d};
            cnt_q  <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
              st_q  <= (post_q == SFD_RD && dum_q != 2'h0) ? SFD_DUM : post_q;
              cnt_q <= {1'b0, dum_q};
            end
          end
          SFD_DUM: begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) st_q <= SFD_RD;
          end
          default: ;
        endcase
      end
    end
  end

  // ========================================================================
  // data bytes written in: status bytes and page buffer
  assign buf_we = byte_done && st_q == SFD_WR
               && (op_q == `SFD_OP_PROG || op_q == `SFD_OP_QPROG);
  assign buf_wa = addr_q[7:0] + wptr_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb0_q  <= 8'h00;
      wb1_q  <= 8'h00;
      wcnt_q <= 9'h000;
      wptr_q <= 8'h00;
    end else if (cs_fall) begin
      wcnt_q <= 9'h000;
      wptr_q <= 8'h00;
    end else if (byte_done && st_q == SFD_WR) begin
      if (nb_q == 4'h1) wb0_q <= sh_d;
      if (nb_q == 4'h2) wb1_q <= sh_d;
      if (buf_we && wcnt_q != `SFD_PAGE_BYTES) wcnt_q <= wcnt_q + 9'h001;
      if (buf_we) wptr_q <= wptr_q + 8'h01; // keeps wrapping past a full page
    end
  end

  sfd_page_buf #(
    .AW (8),
    .DW (8)
  ) u_page_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .wr_en     (buf_we),
    .wr_addr   (buf_wa),
    .wr_data   (sh_d),
    .rd_addr   (buf_rd_addr),
    .rd_data_q (buf_rd_data)
  );

  // ========================================================================
  // returned bytes on falling edges
  logic [7:0]  osh_q;
  logic [2:0]  obc_q;
  logic        idt_q;
  logic [7:0]  nxt_byte;
  logic [7:0]  cur;
  logic [3:0]  ostep;
  logic        rd_q;

  always_comb begin
    unique case (src_q)
      SRC_SLO:  nxt_byte = status_low_byte;
      SRC_SHI:  nxt_byte = status_high_byte;
      SRC_ID:   nxt_byte = idt_q ? PART_CODE : MAKER_CODE;
      SRC_PART: nxt_byte = PART_CODE;
      default:  nxt_byte = arr_rd_data;
    endcase
  end

  assign cur   = (obc_q == 3'h0) ? nxt_byte : osh_q;
  assign ostep = lane_bits(dln_q);

  // read entry delayed, so the start address holds its last byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= (st_q == SFD_RD);
    end
  end

  // output shifter, array address and id alternation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_out   <= 4'h0;
      io_oe    <= 4'h0;
      osh_q    <= 8'h00;
      obc_q    <= 3'h0;
      idt_q    <= 1'b0;
      arr_addr <= 24'h00_0000;
    end else if (!sel || st_q != SFD_RD || !rd_q) begin
      io_oe    <= 4'h0;
      obc_q    <= 3'h0;
      idt_q    <= start_addr[0];
      arr_addr <= start_addr;
    end else if (sck_fall) begin
      unique case (dln_q)
        LN_1: begin
          io_out <= {2'b00, cur[7], 1'b0};
          io_oe  <= 4'h2;
        end
        LN_2: begin
          io_out <= {2'b00, cur[7:6]};
          io_oe  <= 4'h3;
        end
        default: begin
          io_out <= cur[7:4];
          io_oe  <= quad_lines_enable_bit ? 4'hF : 4'h0;
        end
      endcase
      osh_q <= cur << ostep;
      obc_q <= obc_q + ostep[2:0];
      if (obc_q == 3'h0) begin
        idt_q <= ~idt_q;
        if (src_q == SRC_ARR) arr_addr <= arr_addr + 24'h00_0001;
      end
    end
  end

  // ========================================================================
  // frame end effects: status, modes, program and erase starts
  logic commit;
  logic wel;

  assign commit = cs_rise && bc_q == 3'h0 && st_q == SFD_WR;
  assign wel    = status_low_byte[`SFD_BIT_WEL];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_low_byte        <= `SFD_SLO_RST;
      status_high_byte       <= `SFD_SHI_RST;
      four_line_command_mode <= 1'b0;
      deep_down              <= 1'b0;
      pgm_start              <= 1'b0;
      erase_start            <= 1'b0;
      pgm_len                <= 9'h000;
      tgt_addr               <= 24'h00_0000;
    end else begin
      pgm_start   <= 1'b0;
      erase_start <= 1'b0;
      tgt_addr    <= addr_q[23:0];
      status_low_byte[`SFD_BIT_BUSY] <= busy;
      if (cs_rise && op_q == `SFD_OP_WAKE && st_q != SFD_OPC && st_q != SFD_IGN) begin
        deep_down <= 1'b0;
      end
      if (commit) begin
        unique case (op_q)
          `SFD_OP_WREN, `SFD_OP_WREN_V: status_low_byte[`SFD_BIT_WEL] <= 1'b1;
          `SFD_OP_WRDI: status_low_byte[`SFD_BIT_WEL] <= 1'b0;
          `SFD_OP_WR_STAT: if (wel && nb_q >= 4'h2) begin
            status_low_byte[7:2] <= wb0_q[7:2];
            if (nb_q >= 4'h3) status_high_byte[6:0] <= wb1_q[6:0];
            status_low_byte[`SFD_BIT_WEL] <= 1'b0;
          end
          `SFD_OP_WR_SHI: if (wel && nb_q == 4'h2) begin
            status_high_byte[6:0] <= wb0_q[6:0];
            status_low_byte[`SFD_BIT_WEL] <= 1'b0;
          end
          `SFD_OP_PROG, `SFD_OP_QPROG: if (wel && nb_q >= 4'h5 && !prot_hit) begin
            pgm_start <= 1'b1;
            pgm_len   <= wcnt_q;
            status_low_byte[`SFD_BIT_WEL] <= 1'b0;
          end
          `SFD_OP_ER4K, `SFD_OP_ER32K, `SFD_OP_ER64K, `SFD_OP_ERCHIP, `SFD_OP_ERCHIP2:
            if (wel && !prot_hit && (nb_q == 4'h4 || erase_kind == `SFD_ERK_CHIP)) begin
              erase_start <= 1'b1;
              status_low_byte[`SFD_BIT_WEL] <= 1'b0;
            end
          `SFD_OP_HALT:    status_high_byte[`SFD_BIT_SUSP] <= 1'b1;
          `SFD_OP_RESUME:  status_high_byte[`SFD_BIT_SUSP] <= 1'b0;
          `SFD_OP_SLEEP:   deep_down <= 1'b1;
          `SFD_OP_FLM_ON:  four_line_command_mode <= 1'b1;
          `SFD_OP_FLM_OFF: four_line_command_mode <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // erase size follows the opcode held for this frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_kind <= `SFD_ERK_4K;
    end else begin
      unique case (op_q)
        `SFD_OP_ER32K:                   erase_kind <= `SFD_ERK_32K;
        `SFD_OP_ER64K:                   erase_kind <= `SFD_ERK_64K;
        `SFD_OP_ERCHIP, `SFD_OP_ERCHIP2: erase_kind <= `SFD_ERK_CHIP;
        default:                         erase_kind <= `SFD_ERK_4K;
      endcase
    end
  end

  assign quad_lines_enable_bit = status_high_byte[`SFD_BIT_QUAD];
  assign suspend_flag          = status_high_byte[`SFD_BIT_SUSP];

  // ========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_frame_start: assert property (cs_fall |=> st_q == SFD_OPC && bc_q == 3'h0)
    else $error("frame did not restart on select");
  chk_opcode_byte: assert property (st_q == SFD_OPC && byte_done && !cs_fall
    |=> op_q == $past(sh_d)) else $error("opcode not captured");
  chk_msb_first: assert property (sck_rise && !cs_fall && in_ln == LN_1
    |=> sh_q[7:1] == $past(sh_q[6:0]) && sh_q[0] == $past(io_s2_q[0]))
    else $error("single line shift wrong");
  chk_release_end: assert property (cs_rise |=> io_oe == 4'h0)
    else $error("lines held after deselect");
  chk_partial_abort: assert property (cs_rise && bc_q != 3'h0
    |=> !pgm_start && !erase_start && $stable(status_high_byte))
    else $error("partial byte acted on");
  chk_busy_ignore: assert property (st_q == SFD_OPC && byte_done && busy && !cs_fall
    && sh_d != `SFD_OP_RD_SLO && sh_d != `SFD_OP_RD_SHI |=> st_q == SFD_IGN)
    else $error("instruction taken while busy");
  chk_status_out: assert property (st_q == SFD_RD && src_q == SRC_SLO && sck_fall
    && obc_q == 3'h0 && dln_q == LN_1 |=> io_out[1] == $past(status_low_byte[7]))
    else $error("status low byte msb wrong");
  chk_dual_order: assert property (st_q == SFD_RD && sel && sck_fall
    && dln_q == LN_2 |=> io_out[1:0] == $past(cur[7:6]) ##1 io_oe == 4'h3)
    else $error("dual bit order wrong");
  chk_page_count: assert property (wcnt_q <= `SFD_PAGE_BYTES)
    else $error("program count past one page");
  chk_quad_gate: assert property (!quad_lines_enable_bit |-> io_oe[3:2] == 2'b00)
    else $error("upper lines driven without quad bit");
  chk_suspend_set: assert property (commit && op_q == `SFD_OP_HALT
    |=> suspend_flag ##1 suspend_flag) else $error("suspend flag not set");

  cov_status_read: cover property (st_q == SFD_RD && src_q == SRC_SLO && sck_fall);
  cov_program: cover property (pgm_start);
  cov_quad_read: cover property (st_q == SFD_RD && dln_q == LN_4 && sck_fall);
endmodule
`default_nettype wire

// file: rtl/sfd_regs.svh
// opcodes, status fields, reset values and sizes of the instruction decoder
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH
// ==========================================================================
// opcodes
`define SFD_OP_WREN     8'h06
`define SFD_OP_WREN_V   8'h50
`define SFD_OP_WRDI     8'h04
`define SFD_OP_RD_SLO   8'h05
`define SFD_OP_RD_SHI   8'h35
`define SFD_OP_WR_STAT  8'h01
`define SFD_OP_WR_SHI   8'h31
`define SFD_OP_READ     8'h03
`define SFD_OP_FREAD    8'h0B
`define SFD_OP_DOUT     8'h3B
`define SFD_OP_DIO      8'hBB
`define SFD_OP_QOUT     8'h6B
`define SFD_OP_QIO      8'hEB
`define SFD_OP_PROG     8'h02
`define SFD_OP_QPROG    8'h33
`define SFD_OP_ER4K     8'h20
`define SFD_OP_ER32K    8'h52
`define SFD_OP_ER64K    8'hD8
`define SFD_OP_ERCHIP   8'h60
`define SFD_OP_ERCHIP2  8'h7C
`define SFD_OP_HALT     8'h75
`define SFD_OP_RESUME   8'h7A
`define SFD_OP_SLEEP    8'hB9
`define SFD_OP_WAKE     8'hAB
`define SFD_OP_IDS      8'h90
`define SFD_OP_QIDS     8'h94
`define SFD_OP_FLM_ON   8'h38
`define SFD_OP_FLM_OFF  8'hFF
// ==========================================================================
// status fields and reset values
`define SFD_BIT_BUSY    0
`define SFD_BIT_WEL     1
`define SFD_BIT_QUAD    1
`define SFD_BIT_SUSP    7
`define SFD_SLO_RST     8'h00
`define SFD_SHI_RST     8'h00
// ==========================================================================
// sizes and erase kinds
`define SFD_PAGE_BYTES  9'h100
`define SFD_ERK_4K      2'h0
`define SFD_ERK_32K     2'h1
`define SFD_ERK_64K     2'h2
`define SFD_ERK_CHIP    2'h3
`endif

// file: rtl/sfd_pkg.sv
// types shared by the instruction decoder
package sfd_pkg;
  // ========================================================================
  // frame phases
  typedef enum {SFD_OPC, SFD_ADR, SFD_DUM, SFD_RD, SFD_WR, SFD_IGN} sfd_state_e;
  // lines used per phase
  typedef enum logic [1:0] {LN_1, LN_2, LN_4} sfd_lane_e;
  // source of returned bytes
  typedef enum logic [2:0] {SRC_SLO, SRC_SHI, SRC_ID, SRC_PART, SRC_ARR} sfd_src_e;
endpackage

// file: rtl/sfd_page_buf.sv
// page buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module sfd_page_buf #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data_q
);
  // ========================================================================
  // storage
  logic [DW-1:0] mem [2**AW];

  // write side, no reset on the array
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// file: tb/sfd_host_model.sv
// host controller model that frames instructions on the serial link
`timescale 1ns/10ps
`default_nettype none
module sfd_host_model (
  // clock
  input  wire logic       clk,
  // serial link pins
  output var  logic       sck,
  output var  logic       cs_n,
  output var  logic [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  // idle: clock still low, deselected, spare lines pulled up
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'hF;
  end
  // select low opens a frame
  task automatic sel();
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // select high four clocks after the last bit, released data line inverted, idle gap
  task automatic desel();
    repeat (4) @(posedge clk);
    cs_n     <= 1'b1;
    io_in[0] <= ~io_in[0];
    repeat (8) @(posedge clk);
  endtask
  // nb bits msb first, line 1 captured in each high phase
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      io_in[0] <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk) rx[i] = io_oe[1] ? io_out[1] : 1'b1; // released line pulled up
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/sfd_decoder_test.sv
// self-checking bench of the instruction decoder through a host model
`timescale 1ns/10ps
`default_nettype none
`include "sfd_regs.svh"
module sfd_decoder_test;
  localparam logic [7:0] MK = 8'h5A; // arbitrary value
  localparam logic [7:0] PT = 8'hC3; // arbitrary value
  // stimulus and observed signals
  logic       clk, reset_n, busy, prot_hit, sck, cs_n, pgm_start, ers, susp;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] rx, buf_rd_addr, buf_rd_data, slo, shi;
  logic [8:0] pgm_len;
  logic [8:0] n_pgm = 9'h000;
  logic [8:0] n_ers = 9'h000;
  logic [1:0] ek;
  logic [23:0] arr_a;
  int         n_mismatch, check_count;
  sfd_host_model host_u (.clk(clk), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));
  sfd_decoder #(.MAKER_CODE(MK), .PART_CODE(PT)) dut_u (.clk(clk), .reset_n(reset_n),
    .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .busy(busy),
    .prot_hit(prot_hit), .arr_rd_data(arr_a[7:0]), .arr_addr(arr_a), .tgt_addr(),
    .erase_kind(ek), .pgm_start(pgm_start), .erase_start(ers), .pgm_len(pgm_len),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data), .status_low_byte(slo),
    .status_high_byte(shi), .quad_lines_enable_bit(), .suspend_flag(susp),
    .four_line_command_mode(), .deep_down());
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counts accepted program and erase pulses
  always @(posedge clk) begin
    if (pgm_start === 1'b1) n_pgm <= n_pgm + 9'h001;
    if (ers === 1'b1) n_ers <= n_ers + 9'h001;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // n bytes from the top of b, no framing
  task automatic sendn(input logic [63:0] b, input int n);
    for (int i = 0; i < n; i++) host_u.xfer(b[63-8*i -: 8], 8, rx);
  endtask
  task automatic frame(input logic [63:0] b, input int n);
    host_u.sel();
    sendn(b, n);
    host_u.desel();
  endtask
  // next returned byte
  task automatic rd(input logic [7:0] exp);
    host_u.xfer(8'h00, 8, rx);
    chk(rx, exp);
  endtask
  task automatic rdbuf(input logic [7:0] a, input logic [7:0] exp);
    buf_rd_addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk) chk(buf_rd_data, exp);
    @(posedge clk);
  endtask
  task automatic t_status();
    chk(slo, `SFD_SLO_RST);
    chk(shi, `SFD_SHI_RST);
    frame({`SFD_OP_WREN, 56'h0}, 1);
    chk(slo[1], 1'b1);
    busy <= 1'b1;
    frame({`SFD_OP_WRDI, 56'h0}, 1);
    chk(slo[1], 1'b1);
    host_u.sel();
    sendn({`SFD_OP_RD_SLO, 56'h0}, 1);
    rd(8'h03);
    rd(8'h03);
    host_u.desel();
    busy <= 1'b0;
    frame({24'h01A814, 40'h0}, 3);
    chk(slo[7:2], 6'h2A);
    chk(shi, 8'h14);
    host_u.sel();
    sendn({`SFD_OP_RD_SHI, 56'h0}, 1);
    rd(8'h14);
    rd(8'h14);
    host_u.desel();
    frame({`SFD_OP_WREN, 56'h0}, 1);
    host_u.sel();
    sendn({`SFD_OP_WR_SHI, 56'h0}, 1);
    host_u.xfer(8'h40, 4, rx);
    host_u.desel();
    chk(shi, 8'h14);
    frame({`SFD_OP_WREN, 56'h0}, 1);
    frame({16'h3120, 48'h0}, 2);
    chk(shi, 8'h20);
    $display("status test done");
  endtask
  task automatic t_ids();
    host_u.sel();
    sendn({32'h90000001, 32'h0}, 4);
    rd(PT);
    rd(MK);
    host_u.desel();
    for (int k = 0; k < 2; k++) begin
      host_u.sel();
      sendn({(k == 0) ? 8'hC7 : `SFD_OP_QOUT, 56'h0}, 6);
      chk(io_oe, 4'h0);
      host_u.desel();
    end
    $display("id test done");
  endtask
  task automatic t_prog();
    frame({`SFD_OP_WREN, 56'h0}, 1);
    frame({56'h020000FE112233, 8'h0}, 7);
    chk(n_pgm, 9'h001);
    chk(pgm_len, 9'h003);
    rdbuf(8'hFF, 8'h22);
    rdbuf(8'h00, 8'h33);
    prot_hit <= 1'b1;
    frame({`SFD_OP_WREN, 56'h0}, 1);
    frame({40'h0200001055, 24'h0}, 5);
    chk(n_pgm, 9'h001);
    $display("program test done");
  endtask
  // one framed status low read
  task automatic rd_status(input logic [7:0] exp);
    host_u.sel();
    sendn({`SFD_OP_RD_SLO, 56'h0}, 1);
    rd(exp);
    host_u.desel();
  endtask
  task automatic t_modes();
    host_u.sel();
    sendn({`SFD_OP_READ, 24'h000010, 32'h0}, 4);
    rd(8'h10);
    rd(8'h11);
    host_u.desel();
    prot_hit <= 1'b0;
    frame({`SFD_OP_WREN, 56'h0}, 1);
    frame({`SFD_OP_ER32K, 24'h012000, 32'h0}, 4);
    chk(n_ers, 9'h001);
    chk(ek, `SFD_ERK_32K);
    frame({`SFD_OP_HALT, 56'h0}, 1);
    chk(susp, 1'b1);
    frame({`SFD_OP_RESUME, 56'h0}, 1);
    chk(susp, 1'b0);
    frame({`SFD_OP_SLEEP, 56'h0}, 1);
    rd_status(8'hFF);
    host_u.sel();
    sendn({`SFD_OP_WAKE, 56'h0}, 4);
    rd(PT);
    host_u.desel();
    rd_status(8'hA8);
    $display("mode test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    reset_n = 1'b0;
    busy = 1'b0;
    prot_hit = 1'b0;
    buf_rd_addr = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_status();
    t_ids();
    t_prog();
    t_modes();
    final_report();
  end
endmodule
`default_nettype wire
